// ---- verilog/eic_pkg.sv ----
// Purpose: shared constants and types for the encoder input conditioning block
// Assumes: 16-bit register port, 16-bit position count
// Notes:   control register offsets are local choices
package eic_pkg;
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 16;
    localparam int          CNT_W            = 16;
    localparam logic [3:0]  ADDR_IO_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_MODE_CTRL   = 4'h1;
    localparam logic [3:0]  ADDR_STATUS      = 4'h2;
    localparam logic [15:0] IO_CTRL_RESET    = 16'h0000;
    localparam logic [15:0] IO_CTRL_WMASK    = 16'hfff0;
    localparam logic [15:0] MODE_CTRL_RESET  = 16'h0000;
    localparam logic [15:0] MODE_CTRL_WMASK  = 16'h0007;
    localparam int          FLT_DIV_W        = 7;
    localparam logic [1:0]  FLT_STABLE_COUNT = 2'h3;

    typedef enum logic [1:0] {
        EIC_MODE_QUAD    = 2'b00,
        EIC_MODE_EXT_UD  = 2'b01,
        EIC_MODE_EXT_GT  = 2'b10,
        EIC_MODE_TMR_GT  = 2'b11
    } eic_mode_t;

    typedef enum logic [1:0] {
        EIC_OUT_OFF      = 2'b00,
        EIC_OUT_GE_UPPER = 2'b01,
        EIC_OUT_LT_LOWER = 2'b10,
        EIC_OUT_OUTSIDE  = 2'b11
    } eic_out_t;

    // io control layout, bit 15 down to bit 0
    typedef struct packed {
        logic       index_capture_enable;
        logic       input_filter_enable;
        logic [2:0] filter_clock_divide;
        eic_out_t   compare_output_function;
        logic       phase_swap;
        logic       home_polarity;
        logic       index_polarity;
        logic       phase_b_polarity;
        logic       phase_a_polarity;
        logic [3:0] pin_state;
    } eic_io_ctrl_t;

    // home, index, phase b, phase a
    typedef struct packed {
        logic home;
        logic index;
        logic phase_b;
        logic phase_a;
    } eic_pins_t;
endpackage

// ---- verilog/eic_filter.sv ----
// Purpose: digital noise filter for the four encoder inputs
// Assumes: inputs already synchronous to sys_clk
// Notes:   an input must hold for three divided ticks before it passes
`timescale 1ns/100ps
module eic_filter (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic [2:0]        divide,
    input  wire eic_pkg::eic_pins_t pins_in,
    output eic_pkg::eic_pins_t     pins_out
);
    import eic_pkg::*;

    logic [FLT_DIV_W-1:0] div_reg, div_next;
    logic [FLT_DIV_W-1:0] div_limit;
    logic                 tick;

    always_comb begin
        div_limit = FLT_DIV_W'((8'h01 << divide) - 8'h01);
        // a shorter divide must not wait for the counter to wrap
        tick      = (div_reg >= div_limit);
        div_next  = tick ? '0 : div_reg + FLT_DIV_W'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    eic_pins_t filt_reg;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bit
            logic [1:0] cnt_reg, cnt_next;
            logic       val_reg, val_next;
            always_comb begin
                cnt_next = cnt_reg;
                val_next = val_reg;
                if (pins_in[i] == val_reg) begin
                    cnt_next = '0;
                end else if (tick) begin
                    if (cnt_reg == FLT_STABLE_COUNT - 2'h1) begin
                        val_next = pins_in[i];
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 2'h1;
                    end
                end
            end
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cnt_reg <= '0;
                    val_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_next;
                    val_reg <= val_next;
                end
            end
            assign filt_reg[i] = val_reg;
        end
    endgenerate

    // R4 filter or bypass
    assign pins_out = enable ? filt_reg : pins_in;
endmodule

// ---- verilog/eic_compare.sv ----
// Purpose: compare output from position count and two thresholds
// Assumes: unsigned count and thresholds
// Notes:   output registered, one cycle behind the count
`timescale 1ns/100ps
module eic_compare (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire eic_pkg::eic_out_t        func,
    input  wire logic [eic_pkg::CNT_W-1:0] position_count,
    input  wire logic [eic_pkg::CNT_W-1:0] lower_compare_threshold,
    input  wire logic [eic_pkg::CNT_W-1:0] upper_compare_threshold,
    output logic                          compare_output_pin
);
    import eic_pkg::*;

    logic out_reg, out_next;

    // R6 output function select
    always_comb begin
        case (func)
            EIC_OUT_OFF:      out_next = 1'b0;
            EIC_OUT_GE_UPPER: out_next = position_count >= upper_compare_threshold;
            EIC_OUT_LT_LOWER: out_next = position_count < lower_compare_threshold;
            EIC_OUT_OUTSIDE:  out_next = (position_count < lower_compare_threshold)
                                      || (position_count > upper_compare_threshold);
            default:          out_next = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign compare_output_pin = out_reg;
endmodule

// ---- verilog/eic_top.sv ----
// Purpose: input conditioning and mode selection for a quadrature encoder
// Assumes: pins synchronous to sys_clk, single clock, synchronous reset
// Notes:   counter itself lives outside; this block hands it conditioned inputs
//
// Summary of operation
// R1: gate enable lets gate pin control counting
// R2: mode field picks one of four counting modes
// R3: index rising edge captures count if enabled
// R4: filter enable routes inputs through noise filter
// R5: filter clock divided by two to the code
// R6: compare output function against two thresholds
// R7: swap bit exchanges phase A and B
// R8: home polarity bit inverts home input
// R9: polarity bits writable, pin bits read-only
// R10: each polarity bit inverts its input
// R11: pin status sampled, writes ignored there
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
module eic_top (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [eic_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [eic_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [eic_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        phase_a_input,
    input  wire logic                        phase_b_input,
    input  wire logic                        index_pin,
    input  wire logic                        home_pin,
    input  wire logic                        gate_pin,
    input  wire logic [eic_pkg::CNT_W-1:0]   position_count,
    input  wire logic [eic_pkg::CNT_W-1:0]   lower_compare_threshold,
    input  wire logic [eic_pkg::CNT_W-1:0]   upper_compare_threshold,
    output eic_pkg::eic_mode_t               counter_mode,
    output logic                             count_enable,
    output logic                             quad_a,
    output logic                             quad_b,
    output logic                             ext_clock,
    output logic                             ext_direction,
    output logic                             index_cond,
    output logic                             home_cond,
    output logic                             capture_strobe,
    output logic [eic_pkg::CNT_W-1:0]        capture_value,
    output logic                             compare_output_pin
);
    import eic_pkg::*;

    eic_io_ctrl_t        ctrl_reg, ctrl_next;
    logic [2:0]          mode_reg, mode_next;
    eic_pins_t           pin_reg, pin_next;
    logic [DATA_W-1:0]   rdata_reg, rdata_next;
    logic [CNT_W-1:0]    cap_reg, cap_next;
    logic                cap_stb_reg, cap_stb_next;
    logic                index_prev_reg, index_prev_next;
    eic_pins_t           pol_pins;
    eic_pins_t           filt_pins;
    logic                external_gate_enable;
    eic_mode_t           counter_mode_select;
    logic                index_rise;

    assign external_gate_enable = mode_reg[2];
    assign counter_mode_select  = eic_mode_t'(mode_reg[1:0]);

    // register port and pin sampling
    always_comb begin
        ctrl_next  = ctrl_reg;
        mode_next  = mode_reg;
        rdata_next = '0;
        // R11 pins sampled each clock
        pin_next   = '{home: home_pin, index: index_pin,
                       phase_b: phase_b_input, phase_a: phase_a_input};
        if (reg_wr) begin
            case (reg_addr)
                // R9 writable polarity and control bits only
                ADDR_IO_CTRL: ctrl_next = eic_io_ctrl_t'(
                    (reg_wdata & IO_CTRL_WMASK) | (ctrl_reg & ~IO_CTRL_WMASK));
                ADDR_MODE_CTRL: mode_next = 3'(reg_wdata & MODE_CTRL_WMASK);
                default: ;
            endcase
        end
        // R11 status field tracks pins, not writes
        ctrl_next.pin_state = pin_reg;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_IO_CTRL:   rdata_next = ctrl_reg;
                ADDR_MODE_CTRL: rdata_next = DATA_W'(mode_reg);
                ADDR_STATUS:    rdata_next = DATA_W'(cap_reg);
                default:        rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg  <= eic_io_ctrl_t'(IO_CTRL_RESET);
            mode_reg  <= 3'(MODE_CTRL_RESET);
            pin_reg   <= '0;
            rdata_reg <= '0;
        end else begin
            ctrl_reg  <= ctrl_next;
            mode_reg  <= mode_next;
            pin_reg   <= pin_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // R10 polarity before filtering
    // R8 home inversion
    always_comb begin
        pol_pins.phase_a = pin_reg.phase_a ^ ctrl_reg.phase_a_polarity;
        pol_pins.phase_b = pin_reg.phase_b ^ ctrl_reg.phase_b_polarity;
        pol_pins.index   = pin_reg.index   ^ ctrl_reg.index_polarity;
        pol_pins.home    = pin_reg.home    ^ ctrl_reg.home_polarity;
    end

    // R4 filter path
    // R5 divide code feeds filter clock
    eic_filter u_filter (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .enable   (ctrl_reg.input_filter_enable),
        .divide   (ctrl_reg.filter_clock_divide),
        .pins_in  (pol_pins),
        .pins_out (filt_pins)
    );

    // R3 index edge capture
    always_comb begin
        index_prev_next    = filt_pins.index;
        index_rise         = filt_pins.index && !index_prev_reg;
        cap_next           = cap_reg;
        cap_stb_next       = 1'b0;
        if (index_rise && ctrl_reg.index_capture_enable) begin
            cap_next     = position_count;
            cap_stb_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            index_prev_reg    <= 1'b0;
            cap_reg           <= '0;
            cap_stb_reg       <= 1'b0;
        end else begin
            index_prev_reg    <= index_prev_next;
            cap_reg           <= cap_next;
            cap_stb_reg       <= cap_stb_next;
        end
    end

    assign capture_strobe = cap_stb_reg;
    assign capture_value  = cap_reg;

    // decoder-facing outputs; combinational, phases, index and home from filtered state, count enable from gate_pin when gate enable is set, else held high
    always_comb begin
        // R7 phase swap
        quad_a = ctrl_reg.phase_swap ? filt_pins.phase_b : filt_pins.phase_a;
        quad_b = ctrl_reg.phase_swap ? filt_pins.phase_a : filt_pins.phase_b;
        index_cond    = filt_pins.index;
        home_cond     = filt_pins.home;
        counter_mode  = counter_mode_select;
        ext_clock     = 1'b0;
        ext_direction = 1'b0;
        // R2 mode routing
        case (counter_mode_select)
            EIC_MODE_QUAD:   ext_clock = 1'b0;
            EIC_MODE_EXT_UD: begin
                ext_clock     = quad_a;
                ext_direction = quad_b;
            end
            EIC_MODE_EXT_GT: ext_clock = quad_a;
            EIC_MODE_TMR_GT: ext_clock = 1'b0;
            default:         ext_clock = 1'b0;
        endcase
        // R1 gate pin only counts when enabled
        count_enable = external_gate_enable ? gate_pin : 1'b1;
    end

    eic_compare u_compare (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .func                    (ctrl_reg.compare_output_function),
        .position_count          (position_count),
        .lower_compare_threshold (lower_compare_threshold),
        .upper_compare_threshold (upper_compare_threshold),
        .compare_output_pin      (compare_output_pin)
    );
endmodule

// ---- tb/eic_assertions.sv ----
// Purpose: port-level checks for the encoder input conditioning block
// Assumes: control bits shadowed from register writes seen at the ports
// Notes:   filter timing is judged by the bench, not here
`timescale 1ns/100ps
module eic_assertions (
    input logic               sys_clk,
    input logic               rst,
    input logic [3:0]         reg_addr,
    input logic [15:0]        reg_wdata,
    input logic               reg_wr,
    input logic               reg_rd,
    input logic [15:0]        reg_rdata,
    input logic               phase_a_input,
    input logic               phase_b_input,
    input logic               index_pin,
    input logic               home_pin,
    input logic               gate_pin,
    input logic [15:0]        position_count,
    input logic [15:0]        lower_compare_threshold,
    input logic [15:0]        upper_compare_threshold,
    input eic_pkg::eic_mode_t counter_mode,
    input logic               count_enable,
    input logic               quad_a,
    input logic               quad_b,
    input logic               ext_clock,
    input logic               ext_direction,
    input logic               index_cond,
    input logic               home_cond,
    input logic               capture_strobe,
    input logic [15:0]        capture_value,
    input logic               compare_output_pin
);
    import eic_pkg::*;
    logic [15:0] io_sh;
    logic [2:0]  md_sh;
    logic        cmp_now;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_sh <= 16'h0000;
            md_sh <= 3'h0;
        end else if (reg_wr && reg_addr == ADDR_IO_CTRL) begin
            io_sh <= reg_wdata & IO_CTRL_WMASK;
        end else if (reg_wr && reg_addr == ADDR_MODE_CTRL) begin
            md_sh <= reg_wdata[2:0];
        end
    end
    assign cmp_now = (io_sh[10:9] == 2'h1) ? position_count >= upper_compare_threshold :
                     (io_sh[10:9] == 2'h2) ? position_count < lower_compare_threshold :
                     (io_sh[10:9] == 2'h3) && (position_count < lower_compare_threshold
                                            || position_count > upper_compare_threshold);
    AST_GATE: assert property (count_enable == (md_sh[2] ? gate_pin : 1'h1))
        else $error("count enable does not follow gate setting");
    AST_MODE: assert property (counter_mode == md_sh[1:0])
        else $error("counter mode differs from written field");
    AST_EXT: assert property (ext_clock == ((md_sh[1] ^ md_sh[0]) && quad_a)
        && ext_direction == (md_sh[1:0] == 2'h1 && quad_b))
        else $error("external clock or direction wrong for mode");
    AST_CMP: assert property (compare_output_pin == $past(cmp_now))
        else $error("compare output wrong");
    AST_CAPR: assert property ($rose(index_cond) && io_sh[15] |=> capture_strobe
        && capture_value == $past(position_count))
        else $error("index rise did not capture the count");
    AST_CAPS: assert property (capture_strobe |-> $past(index_cond)
        && !$past(index_cond, 2) && $past(io_sh[15]))
        else $error("capture without enabled index rise");
    AST_QA: assert property (!io_sh[14] && !$past(rst) |-> quad_a == (io_sh[8]
        ? $past(phase_b_input) ^ io_sh[5] : $past(phase_a_input) ^ io_sh[4]))
        else $error("phase a path wrong");
    AST_QB: assert property (!io_sh[14] && !$past(rst) |-> quad_b == (io_sh[8]
        ? $past(phase_a_input) ^ io_sh[4] : $past(phase_b_input) ^ io_sh[5]))
        else $error("phase b path wrong");
    AST_IH: assert property (!io_sh[14] && !$past(rst)
        |-> index_cond == ($past(index_pin) ^ io_sh[6])
        && home_cond == ($past(home_pin) ^ io_sh[7]))
        else $error("index or home path wrong");
    AST_RDIO: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_IO_CTRL
        |-> reg_rdata == {$past(io_sh[15:4]), $past(home_pin, 3), $past(index_pin, 3),
                          $past(phase_b_input, 3), $past(phase_a_input, 3)})
        else $error("io control readback wrong");
    AST_RDZ: assert property (!$past(reg_rd) || $past(reg_addr) > ADDR_STATUS
        |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
endmodule
bind eic_top eic_assertions eic_assertions_i (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .phase_a_input, .phase_b_input, .index_pin, .home_pin, .gate_pin,
    .position_count, .lower_compare_threshold, .upper_compare_threshold,
    .counter_mode, .count_enable, .quad_a, .quad_b, .ext_clock, .ext_direction,
    .index_cond, .home_cond, .capture_strobe, .capture_value, .compare_output_pin
);

// ---- tb/eic_encoder_model.sv ----
// Purpose: encoder stand-in driving phase, index and home pins
// Assumes: one step per clock while step is high, forward only
// Notes:   gray sequence, so a step moves one phase at a time
`timescale 1ns/100ps
module eic_encoder_model (
    input  logic sys_clk,
    input  logic rst,
    input  logic step,
    input  logic idx_lvl,
    input  logic home_lvl,
    output logic phase_a_input,
    output logic phase_b_input,
    output logic index_pin,
    output logic home_pin
);
    logic [1:0] pos_reg;
    logic [1:0] pos_next;
    always_comb begin
        pos_next = step ? pos_reg + 2'h1 : pos_reg;
    end
    always_ff @(posedge sys_clk) begin
        pos_reg <= rst ? 2'h0 : pos_next;
    end
    assign phase_a_input = pos_reg[1] ^ pos_reg[0];
    assign phase_b_input = pos_reg[1];
    assign index_pin     = idx_lvl;
    assign home_pin      = home_lvl;
endmodule

// ---- tb/testbench.sv ----
// Purpose: register-driven tests of the encoder input conditioning block
// Assumes: drives on rising edges, checks on falling edges
// Notes:   filter latency checked as a window, divider phase is unknown
`timescale 1ns/100ps
module testbench;
    import eic_pkg::*;
    logic        sys_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic        gate_pin = 1'h0, step = 1'h0, idx_lvl = 1'h0, home_lvl = 1'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, position_count = 16'h0000;
    logic [15:0] lower_compare_threshold = 16'h0064, upper_compare_threshold = 16'h00c8;
    logic [15:0] reg_rdata, capture_value;
    logic        phase_a_input, phase_b_input, index_pin, home_pin, count_enable, quad_a;
    logic        quad_b, ext_clock, ext_direction, index_cond, home_cond, capture_strobe;
    logic        compare_output_pin;
    eic_mode_t   counter_mode;
    logic [15:0] cnts [4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
    int          error_cnt = 0, checked = 0, strobes = 0, n;
    eic_top eic_top_i (.*);
    eic_encoder_model eic_encoder_model_i (.sys_clk, .rst, .step, .idx_lvl, .home_lvl,
        .phase_a_input, .phase_b_input, .index_pin, .home_pin);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (capture_strobe === 1'h1) strobes <= strobes + 1;
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic go(int c);
        repeat (c) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic stp(int c);
        @(posedge sys_clk);
        step <= 1'h1;
        repeat (c) @(posedge sys_clk);
        step <= 1'h0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        rd(ADDR_IO_CTRL, 16'h0000);
        rd(ADDR_MODE_CTRL, 16'h0000);
        rd(4'h7, 16'h0000);
        $display("test reset done");
        stp(2);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MODE_CTRL, 16'(i));
            gate_pin <= ~i[0];
            go(0);
            chk("counter_mode", i[1:0], counter_mode);
            chk("count_enable", i[2] ? !i[0] : 1'h1, count_enable);
            chk("ext_clock", i[1] ^ i[0], ext_clock);
            chk("ext_direction", i[1:0] == 2'h1, ext_direction);
        end
        $display("test mode and gate done");
        stp(1);
        @(posedge sys_clk) idx_lvl <= 1'h1;
        for (int k = 0; k < 32; k++) begin
            wr(ADDR_IO_CTRL, 16'(k << 4));
            go(0);
            chk("quad_a", k[4] ? !k[1] : k[0], quad_a);
            chk("quad_b", k[4] ? k[0] : !k[1], quad_b);
            chk("index_cond", !k[2], index_cond);
            chk("home_cond", k[3], home_cond);
        end
        wr(ADDR_IO_CTRL, 16'hffff);
        rd(ADDR_IO_CTRL, 16'hfff6);
        $display("test polarity and swap done");
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_IO_CTRL, 16'(f << 9));
            for (int j = 0; j < 4; j++) begin
                @(posedge sys_clk) position_count <= cnts[j];
                go(1);
                chk("compare_output_pin", (f == 1 && cnts[j] >= upper_compare_threshold)
                    || (f[1] && cnts[j] < lower_compare_threshold)
                    || (f == 3 && cnts[j] > upper_compare_threshold), compare_output_pin);
            end
        end
        $display("test compare done");
        for (int e = 1; e >= 0; e--) begin
            wr(ADDR_IO_CTRL, 16'(e << 15));
            idx_lvl        <= 1'h0;
            position_count <= 16'(16'h1234 + e);
            go(3);
            @(posedge sys_clk) idx_lvl <= 1'h1;
            go(3);
            chk("capture count", 16'h0001, 16'(strobes));
            rd(ADDR_STATUS, 16'h1235);
        end
        $display("test capture done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_IO_CTRL, 16'(16'h4000 | c << 11));
            go((4 << c) + 4);
            stp(1);
            // let the step reach the pins before polling
            go(0);
            n = 0;
            while ({quad_a, quad_b} !== {phase_a_input, phase_b_input} && n < 2000) begin
                go(1);
                n++;
            end
            chk("filter delay low", 16'h0001, 16'(n >= (2 << c)));
            chk("filter delay high", 16'h0001, 16'(n <= (3 << c) + 8));
        end
        $display("test filter done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end
endmodule
